// [rtl/counter_array_capture_compare.sv]
/*
 Counter array with three capture/compare modules on the special function register bus.
 Assumes count_tick is a one-cycle pulse of the selected counter clock on clk,
 and that the watchdog enable level comes from the counter mode register logic.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Each module runs capture, timer, fast output, frequency, short or wide PWM.
// - All short PWM modules share one cycle length.
// - Module interrupt request is event flag gated by its interrupt enable bit.
// - Capture edge chosen by mode bits 5 and 4: rising, falling, both.
// - Comparator off: outputs hold, PWM outputs forced low.
// - Cycle length code 0..7 gives PWM length 8..15 bits.
// - Mode bit 7 selects wide PWM; config bit 3 selects auto-reload.
// - Reload window bit steers compare byte accesses to reload registers.
// - Config bit enables interrupt on overflow of the selected short length bit.
// - Match flag enable lets a comparator match set the event flag.
// - Frequency mode toggles pin on low byte match, adds high byte to low.
// - Frequency is counter clock over twice high byte; zero counts 256.
// - Frequency mode with match flag sets event on full 16-bit match.
// - Wide PWM goes high on match; counter overflow wins and drives it low, or high if the next compare is zero.
// - Auto-reload value takes effect at the next PWM period.
// - Wide PWM sets event on match and overflow flag on wrap.
// - Compare low write clears comparator enable; high write sets it.
// - Wide PWM duty is (65535 minus compare) over 65536; a compare of zero gives full duty.
// - Counter writes ignored while watchdog enable is set.
// - Counter high read returns snapshot loaded when low byte is read.
module counter_array_capture_compare
	import cca_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic count_tick,
	input wire logic watchdog_enable_bit,
	input wire logic [NUM_MODULES-1:0] module_pin_in,
	output logic [NUM_MODULES-1:0] module_pin_out,
	output logic [NUM_MODULES-1:0] module_pin_oe_n,
	output logic [NUM_MODULES-1:0] module_irq,
	output logic cycle_overflow_irq,
	output logic counter_overflow_flag
);

	logic [15:0] counter_r;
	logic [7:0] snapshot_r;
	logic counter_run_r;
	logic [NUM_MODULES-1:0] module_event_flag_r;
	logic [7:0] module_mode_register_r [NUM_MODULES];
	logic reload_window_select_r;
	logic cycle_flag_r;
	logic cycle_irq_en_r;
	logic auto_reload_r;
	logic [2:0] cycle_length_field_r;
	logic tick;
	logic wr_counter_low;
	logic wr_counter_high;
	logic wr_control;
	logic wr_pwm_config;
	logic [NUM_MODULES-1:0] wr_mode;
	logic [NUM_MODULES-1:0] wr_cmp_low;
	logic [NUM_MODULES-1:0] wr_cmp_high;
	logic [NUM_MODULES-1:0] rd_cmp_low;
	logic [NUM_MODULES-1:0] rd_cmp_high;
	logic [NUM_MODULES-1:0] match_event;
	logic [NUM_MODULES-1:0] pin_level;
	logic [7:0] cmp_low_data [NUM_MODULES];
	logic [7:0] cmp_high_data [NUM_MODULES];
	logic [15:0] cyc_mask;
	logic cycle_wrap;
	logic counter_wrap;
	logic [7:0] read_value;

	////////////////////////////////////////////////////////////////////////
	// Address decode

	always_comb
	begin
		tick = count_tick && counter_run_r;
		wr_counter_low = sfr_wr && sfr_addr == ADDR_COUNTER_LOW && !watchdog_enable_bit;
		wr_counter_high = sfr_wr && sfr_addr == ADDR_COUNTER_HIGH && !watchdog_enable_bit;
		wr_control = sfr_wr && sfr_addr == ADDR_COUNTER_CONTROL;
		wr_pwm_config = sfr_wr && sfr_addr == ADDR_PWM_CONFIG;
		for (int i = 0; i < NUM_MODULES; i++)
		begin
			wr_mode[i] = sfr_wr && sfr_addr == 8'(ADDR_MODE_BASE + i);
			wr_cmp_low[i] = sfr_wr && sfr_addr == 8'(ADDR_COMPARE_LOW_BASE + 2 * i);
			wr_cmp_high[i] = sfr_wr && sfr_addr == 8'(ADDR_COMPARE_HIGH_BASE + 2 * i);
			rd_cmp_low[i] = sfr_addr == 8'(ADDR_COMPARE_LOW_BASE + 2 * i);
			rd_cmp_high[i] = sfr_addr == 8'(ADDR_COMPARE_HIGH_BASE + 2 * i);
		end
		cyc_mask = short_mask(cycle_length_field_r);
		cycle_wrap = tick && (counter_r & cyc_mask) == cyc_mask;
		counter_wrap = tick && counter_r == COUNTER_MAX;
	end

	////////////////////////////////////////////////////////////////////////
	// Counter and snapshot

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			counter_r <= RESET_WORD;
		else if (wr_counter_low)
			counter_r[7:0] <= sfr_wdata;
		else if (wr_counter_high)
			counter_r[15:8] <= sfr_wdata;
		else if (tick)
			counter_r <= 16'(counter_r + 16'h0001);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			snapshot_r <= RESET_BYTE;
		else if (sfr_rd && sfr_addr == ADDR_COUNTER_LOW)
			snapshot_r <= counter_r[15:8];
	end

	////////////////////////////////////////////////////////////////////////
	// Control register and flags

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			counter_run_r <= 1'b0;
			counter_overflow_flag <= 1'b0;
			module_event_flag_r <= '0;
		end
		else
		begin
			if (wr_control)
				counter_run_r <= sfr_wdata[CTRL_RUN];
			if (counter_wrap)
				counter_overflow_flag <= 1'b1;
			else if (wr_control)
				counter_overflow_flag <= sfr_wdata[CTRL_OVF_FLAG];
			for (int i = 0; i < NUM_MODULES; i++)
			begin
				if (match_event[i])
					module_event_flag_r[i] <= 1'b1;
				else if (wr_control)
					module_event_flag_r[i] <= sfr_wdata[i];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reload_window_select_r <= 1'b0;
			cycle_flag_r <= 1'b0;
			cycle_irq_en_r <= 1'b0;
			auto_reload_r <= 1'b0;
			cycle_length_field_r <= 3'h0;
		end
		else
		begin
			if (wr_pwm_config)
			begin
				reload_window_select_r <= sfr_wdata[PWMC_RELOAD_WIN];
				cycle_irq_en_r <= sfr_wdata[PWMC_CYC_IRQ_EN];
				auto_reload_r <= sfr_wdata[PWMC_AUTO_RELOAD];
				cycle_length_field_r <= sfr_wdata[PWMC_CYC_LEN_LSB +: PWMC_CYC_LEN_W];
			end
			if (cycle_wrap)
				cycle_flag_r <= 1'b1;
			else if (wr_pwm_config)
				cycle_flag_r <= sfr_wdata[PWMC_CYC_FLAG];
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < NUM_MODULES; i++)
				module_mode_register_r[i] <= RESET_BYTE;
		end
		else
		begin
			for (int i = 0; i < NUM_MODULES; i++)
			begin
				if (wr_mode[i])
					module_mode_register_r[i] <= sfr_wdata;
				else if (wr_cmp_low[i])
					module_mode_register_r[i][MODE_COMP_EN] <= 1'b0;
				else if (wr_cmp_high[i])
					module_mode_register_r[i][MODE_COMP_EN] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	always_comb
	begin
		read_value = RESET_BYTE;
		if (sfr_addr == ADDR_COUNTER_LOW)
			read_value = counter_r[7:0];
		else if (sfr_addr == ADDR_COUNTER_HIGH)
			read_value = snapshot_r;
		else if (sfr_addr == ADDR_COUNTER_CONTROL)
			read_value = {counter_overflow_flag, counter_run_r, 3'h0, module_event_flag_r};
		else if (sfr_addr == ADDR_PWM_CONFIG)
			read_value = {reload_window_select_r, cycle_flag_r, cycle_irq_en_r, 1'b0,
				auto_reload_r, cycle_length_field_r};
		for (int i = 0; i < NUM_MODULES; i++)
		begin
			if (sfr_addr == 8'(ADDR_MODE_BASE + i))
				read_value = module_mode_register_r[i];
			if (rd_cmp_low[i])
				read_value = cmp_low_data[i];
			if (rd_cmp_high[i])
				read_value = cmp_high_data[i];
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			sfr_rdata <= RESET_BYTE;
		else if (sfr_rd)
			sfr_rdata <= read_value;
	end

	////////////////////////////////////////////////////////////////////////
	// Modules

	for (genvar g = 0; g < NUM_MODULES; g++)
	begin : g_module
		cca_pin_sync u_sync
		(
			.clk(clk),
			.reset_n(reset_n),
			.pin_async(module_pin_in[g]),
			.pin_level(pin_level[g])
		);

		cca_module u_module
		(
			.clk(clk),
			.reset_n(reset_n),
			.count_tick(tick),
			.counter(counter_r),
			.pin_level(pin_level[g]),
			.mode(module_mode_register_r[g]),
			.cycle_length(cycle_length_field_r),
			.auto_reload(auto_reload_r),
			.reload_window(reload_window_select_r),
			.wr_low(wr_cmp_low[g]),
			.wr_high(wr_cmp_high[g]),
			.wdata(sfr_wdata),
			.rd_low_data(cmp_low_data[g]),
			.rd_high_data(cmp_high_data[g]),
			.pin_drive(module_pin_out[g]),
			.match_event(match_event[g])
		);
	end

	always_comb
	begin
		for (int i = 0; i < NUM_MODULES; i++)
		begin
			module_irq[i] = module_mode_register_r[i][MODE_IRQ_EN] && module_event_flag_r[i];
			module_pin_oe_n[i] = !(module_mode_register_r[i][MODE_PWM_EN]
				|| module_mode_register_r[i][MODE_TOGGLE_EN]);
		end
		cycle_overflow_irq = cycle_irq_en_r && cycle_flag_r;
	end

endmodule : counter_array_capture_compare
`default_nettype wire

// [rtl/cca_pkg.sv]
/*
 Constants, mode decoding and mask helpers for the counter array capture/compare block.
 Assumes an 8-bit special function register bus on the system clock.
*/
package cca_pkg;

	localparam int NUM_MODULES = 3;

	// Register addresses
	localparam logic [7:0] ADDR_COUNTER_LOW = 8'hf9;
	localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hfa;
	localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'hd8;
	localparam logic [7:0] ADDR_PWM_CONFIG = 8'hd9;
	localparam logic [7:0] ADDR_MODE_BASE = 8'hda;
	localparam logic [7:0] ADDR_COMPARE_LOW_BASE = 8'he9;
	localparam logic [7:0] ADDR_COMPARE_HIGH_BASE = 8'hea;

	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// Module mode register fields
	localparam int MODE_WIDE_PWM = 7;
	localparam int MODE_COMP_EN = 6;
	localparam int MODE_CAP_POS = 5;
	localparam int MODE_CAP_NEG = 4;
	localparam int MODE_MATCH_EN = 3;
	localparam int MODE_TOGGLE_EN = 2;
	localparam int MODE_PWM_EN = 1;
	localparam int MODE_IRQ_EN = 0;

	// Counter control register fields
	localparam int CTRL_OVF_FLAG = 7;
	localparam int CTRL_RUN = 6;

	// PWM configuration register fields
	localparam int PWMC_RELOAD_WIN = 7;
	localparam int PWMC_CYC_FLAG = 6;
	localparam int PWMC_CYC_IRQ_EN = 5;
	localparam int PWMC_AUTO_RELOAD = 3;
	localparam int PWMC_CYC_LEN_LSB = 0;
	localparam int PWMC_CYC_LEN_W = 3;

	localparam logic [15:0] COUNTER_MAX = 16'hffff;
	localparam logic [15:0] SHORT_MASK_BASE = 16'hff00;

	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_CAPTURE,
		MODE_SW_TIMER,
		MODE_HS_OUT,
		MODE_FREQ_OUT,
		MODE_PWM_SHORT,
		MODE_PWM_WIDE
	} cc_mode_t;

	function automatic cc_mode_t decode_mode(input logic [7:0] m);
		if (m[MODE_CAP_POS] || m[MODE_CAP_NEG])
			decode_mode = MODE_CAPTURE;
		else if (m[MODE_PWM_EN] && m[MODE_WIDE_PWM])
			decode_mode = MODE_PWM_WIDE;
		else if (m[MODE_PWM_EN] && m[MODE_TOGGLE_EN])
			decode_mode = MODE_FREQ_OUT;
		else if (m[MODE_PWM_EN])
			decode_mode = MODE_PWM_SHORT;
		else if (m[MODE_TOGGLE_EN])
			decode_mode = MODE_HS_OUT;
		else if (m[MODE_MATCH_EN])
			decode_mode = MODE_SW_TIMER;
		else
			decode_mode = MODE_IDLE;
	endfunction : decode_mode

	// Mask of the counter bits used by the short PWM length (8 + code bits)
	function automatic logic [15:0] short_mask(input logic [2:0] code);
		short_mask = ~(SHORT_MASK_BASE << code);
	endfunction : short_mask

endpackage : cca_pkg

// [rtl/cca_pin_sync.sv]
/*
 Two-stage synchroniser for one module pin input.
 Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cca_pin_sync
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin_async,
	output logic pin_level
);

	logic meta_r;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_r <= 1'b0;
			pin_level <= 1'b0;
		end
		else
		begin
			meta_r <= pin_async;
			pin_level <= meta_r;
		end
	end

endmodule : cca_pin_sync
`default_nettype wire

// [rtl/cca_module.sv]
/*
 One capture/compare module: compare and reload registers, capture, compare,
 frequency output and PWM output generation.
 Assumes a synchronised pin level and a one-cycle counter tick on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cca_module
	import cca_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic count_tick,
	input wire logic [15:0] counter,
	input wire logic pin_level,
	input wire logic [7:0] mode,
	input wire logic [2:0] cycle_length,
	input wire logic auto_reload,
	input wire logic reload_window,
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wdata,
	output logic [7:0] rd_low_data,
	output logic [7:0] rd_high_data,
	output logic pin_drive,
	output logic match_event
);

	cc_mode_t mode_sel;
	logic [15:0] compare_r;
	logic [15:0] reload_r;
	logic pin_prev_r;
	logic [15:0] mask;
	logic comp_on;
	logic match16;
	logic match_low;
	logic match_short;
	logic ovf_short;
	logic ovf_wide;
	logic edge_hit;
	logic [15:0] next_wide;
	logic [15:0] next_short;
	logic event_nxt;

	////////////////////////////////////////////////////////////////////////
	// Decode and compare

	always_comb
	begin
		mode_sel = decode_mode(mode);
		mask = short_mask(cycle_length);
		comp_on = mode[MODE_COMP_EN];
		match16 = counter == compare_r;
		match_low = counter[7:0] == compare_r[7:0];
		match_short = (counter & mask) == (compare_r & mask);
		ovf_short = (counter & mask) == mask;
		ovf_wide = counter == COUNTER_MAX;
		edge_hit = (mode[MODE_CAP_POS] && pin_level && !pin_prev_r)
			|| (mode[MODE_CAP_NEG] && !pin_level && pin_prev_r);
		next_wide = auto_reload ? reload_r : compare_r;
		if (cycle_length == 3'h0)
			next_short = {compare_r[15:8], compare_r[15:8]};
		else
			next_short = reload_r;
	end

	always_comb
	begin
		event_nxt = 1'b0;
		unique case (mode_sel)
			MODE_CAPTURE: event_nxt = edge_hit;
			MODE_SW_TIMER, MODE_HS_OUT, MODE_FREQ_OUT, MODE_PWM_WIDE:
				event_nxt = count_tick && comp_on && mode[MODE_MATCH_EN] && match16;
			MODE_PWM_SHORT:
				event_nxt = count_tick && comp_on && mode[MODE_MATCH_EN] && match_short;
			MODE_IDLE: event_nxt = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Compare register

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			compare_r <= RESET_WORD;
		else if (wr_low && !reload_window)
			compare_r[7:0] <= wdata;
		else if (wr_high && !reload_window)
			compare_r[15:8] <= wdata;
		else if (mode_sel == MODE_CAPTURE && edge_hit)
			compare_r <= counter;
		else if (count_tick && comp_on)
		begin
			if (mode_sel == MODE_FREQ_OUT && match_low)
				compare_r[7:0] <= 8'(compare_r[7:0] + compare_r[15:8]);
			else if (mode_sel == MODE_PWM_WIDE && ovf_wide)
				compare_r <= next_wide;
			else if (mode_sel == MODE_PWM_SHORT && ovf_short)
				compare_r <= next_short;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reload register

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reload_r <= RESET_WORD;
		else if (wr_low && reload_window)
			reload_r[7:0] <= wdata;
		else if (wr_high && reload_window)
			reload_r[15:8] <= wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin output

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pin_drive <= 1'b0;
		else if (!comp_on)
		begin
			if (mode_sel == MODE_PWM_SHORT || mode_sel == MODE_PWM_WIDE)
				pin_drive <= 1'b0;
		end
		else if (count_tick)
		begin
			unique case (mode_sel)
				MODE_HS_OUT:
					if (match16)
						pin_drive <= !pin_drive;
				MODE_FREQ_OUT:
					if (match_low)
						pin_drive <= !pin_drive;
				MODE_PWM_WIDE:
					if (ovf_wide)
						pin_drive <= next_wide == RESET_WORD;
					else if (match16)
						pin_drive <= 1'b1;
				MODE_PWM_SHORT:
					if (ovf_short)
						pin_drive <= (next_short & mask) == RESET_WORD;
					else if (match_short)
						pin_drive <= 1'b1;
				MODE_IDLE, MODE_CAPTURE, MODE_SW_TIMER: pin_drive <= pin_drive;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_prev_r <= 1'b0;
			match_event <= 1'b0;
		end
		else
		begin
			pin_prev_r <= pin_level;
			match_event <= event_nxt;
		end
	end

	assign rd_low_data = reload_window ? reload_r[7:0] : compare_r[7:0];
	assign rd_high_data = reload_window ? reload_r[15:8] : compare_r[15:8];

endmodule : cca_module
`default_nettype wire

// [tb/cca_pin_partner.sv]
/*
 Far-side circuitry on the module pins.
 Assumes the bench sets ext_level wherever the block leaves a pin undriven.
*/
`timescale 1ns/1ps
`default_nettype none
module cca_pin_partner
	import cca_pkg::*;
(
	input wire logic [NUM_MODULES-1:0] module_pin_out,
	input wire logic [NUM_MODULES-1:0] module_pin_oe_n,
	input wire logic [NUM_MODULES-1:0] ext_level,
	output logic [NUM_MODULES-1:0] pin_wire
);
	// Wire level: block drive when enabled, else the outside level
	assign pin_wire = (module_pin_oe_n & ext_level) | (~module_pin_oe_n & module_pin_out);
endmodule : cca_pin_partner
`default_nettype wire

// [tb/cca_checker.sv]
/*
 Port checker for the capture/compare block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cca_checker
	import cca_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic count_tick,
	input wire logic watchdog_enable_bit,
	input wire logic [NUM_MODULES-1:0] module_pin_in,
	input wire logic [NUM_MODULES-1:0] module_pin_out,
	input wire logic [NUM_MODULES-1:0] module_pin_oe_n,
	input wire logic [NUM_MODULES-1:0] module_irq,
	input wire logic cycle_overflow_irq,
	input wire logic counter_overflow_flag
);
	logic [7:0] mode_r [NUM_MODULES];
	logic [15:0] cnt_r;
	logic [7:0] cnt_lo;
	logic [7:0] snap_r;
	logic run_r;
	logic cyc_en_r;
	logic wrap;
	logic cnt_wr;
	assign cnt_lo = cnt_r[7:0];
	assign cnt_wr = sfr_wr && !watchdog_enable_bit;
	assign wrap = count_tick && run_r && cnt_r == COUNTER_MAX;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	// Shadow of counter and controls
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_r <= RESET_WORD;
			snap_r <= RESET_BYTE;
			run_r <= 1'b0;
			cyc_en_r <= 1'b0;
		end
		else
		begin
			if (sfr_wr && sfr_addr == ADDR_COUNTER_CONTROL)
				run_r <= sfr_wdata[CTRL_RUN];
			if (sfr_wr && sfr_addr == ADDR_PWM_CONFIG)
				cyc_en_r <= sfr_wdata[PWMC_CYC_IRQ_EN];
			if (sfr_rd && sfr_addr == ADDR_COUNTER_LOW)
				snap_r <= cnt_r[15:8];
			if (cnt_wr && sfr_addr == ADDR_COUNTER_LOW)
				cnt_r[7:0] <= sfr_wdata;
			else if (cnt_wr && sfr_addr == ADDR_COUNTER_HIGH)
				cnt_r[15:8] <= sfr_wdata;
			else if (count_tick && run_r)
				cnt_r <= cnt_r + 16'h0001;
		end
	end
	// Shadow of mode registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		for (int i = 0; i < NUM_MODULES; i++)
		begin
			if (!reset_n)
				mode_r[i] <= RESET_BYTE;
			else if (sfr_wr && sfr_addr == ADDR_MODE_BASE + 8'(i))
				mode_r[i] <= sfr_wdata;
			else if (sfr_wr && sfr_addr == ADDR_COMPARE_LOW_BASE + 8'(2 * i))
				mode_r[i][MODE_COMP_EN] <= 1'b0;
			else if (sfr_wr && sfr_addr == ADDR_COMPARE_HIGH_BASE + 8'(2 * i))
				mode_r[i][MODE_COMP_EN] <= 1'b1;
		end
	end
	////////////////////////////////////////
	for (genvar n = 0; n < NUM_MODULES; n++)
	begin : g_mod
		logic wide;
		logic pwm_off;
		logic tog_off;
		assign wide = mode_r[n][MODE_WIDE_PWM] && mode_r[n][MODE_COMP_EN] && mode_r[n][MODE_PWM_EN];
		assign pwm_off = mode_r[n][MODE_PWM_EN] && !mode_r[n][MODE_TOGGLE_EN] && !mode_r[n][MODE_COMP_EN];
		assign tog_off = mode_r[n][MODE_TOGGLE_EN] && !mode_r[n][MODE_COMP_EN];
		chk_irq_needs_enable: assert property (module_irq[n] |-> mode_r[n][MODE_IRQ_EN])
			else $error("module irq without enable");
		chk_pwm_off_low: assert property (pwm_off [*3] |-> !module_pin_out[n])
			else $error("pwm pin high with comparator off");
		chk_off_pin_holds: assert property (tog_off [*3] |-> $stable(module_pin_out[n]))
			else $error("toggle pin moved with comparator off");
		chk_wide_rise_tick: assert property (wide && $past(wide) && $rose(module_pin_out[n])
			|-> $past(count_tick) || $past(count_tick, 2)) else $error("wide pwm rose off tick");
		chk_wide_fall_wrap: assert property (wide && $past(wide) && $fell(module_pin_out[n])
			|-> $past(wrap) || $past(wrap, 2)) else $error("wide pwm fell off wrap");
	end
	chk_cycle_irq_gate: assert property (cycle_overflow_irq |-> cyc_en_r)
		else $error("cycle irq without enable");
	chk_ovf_after_wrap: assert property ($rose(counter_overflow_flag)
		|-> $past(wrap) || $past(wrap, 2) || $past(sfr_wr)) else $error("overflow flag off wrap");
	chk_count_read: assert property (sfr_rd && sfr_addr == ADDR_COUNTER_LOW
		|=> sfr_rdata == $past(cnt_lo)) else $error("counter low read wrong");
	chk_snap_read: assert property (sfr_rd && sfr_addr == ADDR_COUNTER_HIGH
		|=> sfr_rdata == $past(snap_r)) else $error("counter high read not snapshot");
	cov_wrap: cover property (wrap);
	cov_irq: cover property (|module_irq);
	cov_cyc: cover property (cycle_overflow_irq);
endmodule : cca_checker
bind counter_array_capture_compare cca_checker cca_checker_i (.clk, .reset_n, .sfr_addr,
	.sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .count_tick, .watchdog_enable_bit, .module_pin_in,
	.module_pin_out, .module_pin_oe_n, .module_irq, .cycle_overflow_irq, .counter_overflow_flag);
`default_nettype wire

// [tb/counter_array_capture_compare_tb.sv]
/*
 Self-checking bench for the capture/compare block.
 Assumes package, pin partner and bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_compare_tb
	import cca_pkg::*;
;
	logic clk, reset_n, sfr_wr, sfr_rd, count_tick, watchdog_enable_bit;
	logic cycle_overflow_irq, counter_overflow_flag;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [NUM_MODULES-1:0] module_pin_in, module_pin_out, module_pin_oe_n, module_irq, ext_level;
	int fail_count, checks;
	counter_array_capture_compare counter_array_capture_compare_i (.clk, .reset_n, .sfr_addr,
		.sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .count_tick, .watchdog_enable_bit,
		.module_pin_in, .module_pin_out, .module_pin_oe_n, .module_irq, .cycle_overflow_irq,
		.counter_overflow_flag);
	cca_pin_partner cca_pin_partner_i (.module_pin_out, .module_pin_oe_n, .ext_level,
		.pin_wire(module_pin_in));
	always #10 clk = ~clk;
	////////////////////////////////////////
	task automatic close_out();
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
	endtask : rdc
	task automatic tick(input int n);
		repeat (n)
		begin
			@(negedge clk);
			count_tick = 1'b1;
			@(negedge clk);
			count_tick = 1'b0;
			repeat (2) @(negedge clk);
		end
	endtask : tick
	////////////////////////////////////////
	task automatic t_counter();
		rdc(ADDR_COUNTER_LOW, RESET_BYTE);
		rdc(ADDR_COUNTER_HIGH, RESET_BYTE);
		rdc(8'h00, 8'h00);
		wr(ADDR_COUNTER_LOW, 8'hff);
		wr(ADDR_COUNTER_HIGH, 8'h12);
		watchdog_enable_bit = 1'b1;
		wr(ADDR_COUNTER_LOW, 8'h00);
		wr(ADDR_COUNTER_HIGH, 8'h00);
		watchdog_enable_bit = 1'b0;
		rdc(ADDR_COUNTER_LOW, 8'hff);
		rdc(ADDR_COUNTER_HIGH, 8'h12);
		wr(ADDR_COUNTER_CONTROL, 8'h40);
		tick(1);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
		rdc(ADDR_COUNTER_HIGH, 8'h12);
		rdc(ADDR_COUNTER_LOW, 8'h00);
		rdc(ADDR_COUNTER_HIGH, 8'h13);
	endtask : t_counter
	task automatic t_capture();
		wr(ADDR_COUNTER_LOW, 8'h5a);
		wr(ADDR_MODE_BASE, 8'h21);
		ext_level[0] = 1'b1;
		repeat (6) @(negedge clk);
		chk({5'h00, module_irq}, 8'h01);
		rdc(ADDR_COMPARE_LOW_BASE, 8'h5a);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
		ext_level[0] = 1'b0;
		repeat (6) @(negedge clk);
		chk({5'h00, module_irq}, 8'h00);
		wr(ADDR_MODE_BASE, 8'h31);
		ext_level[0] = 1'b1;
		repeat (6) @(negedge clk);
		chk({5'h00, module_irq}, 8'h01);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
		wr(ADDR_MODE_BASE, 8'h10);
		ext_level[0] = 1'b0;
		repeat (6) @(negedge clk);
		chk({5'h00, module_irq}, 8'h00);
		rdc(ADDR_COUNTER_CONTROL, 8'h01);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
		wr(ADDR_MODE_BASE, 8'h00);
	endtask : t_capture
	task automatic t_wide();
		wr(ADDR_MODE_BASE + 8'h01, 8'h8b);
		wr(ADDR_COMPARE_LOW_BASE + 8'h02, 8'hfe);
		rdc(ADDR_MODE_BASE + 8'h01, 8'h8b);
		wr(ADDR_COMPARE_HIGH_BASE + 8'h02, 8'hff);
		rdc(ADDR_MODE_BASE + 8'h01, 8'hcb);
		wr(ADDR_PWM_CONFIG, 8'h20);
		wr(ADDR_COUNTER_LOW, 8'hfd);
		wr(ADDR_COUNTER_HIGH, 8'hff);
		wr(ADDR_COUNTER_CONTROL, 8'h40);
		tick(1);
		chk({7'h00, module_pin_out[1]}, 8'h00);
		tick(1);
		chk({7'h00, module_pin_out[1]}, 8'h01);
		chk({5'h00, module_irq}, 8'h02);
		tick(1);
		chk({7'h00, module_pin_out[1]}, 8'h00);
		chk({7'h00, counter_overflow_flag}, 8'h01);
		chk({7'h00, cycle_overflow_irq}, 8'h01);
		wr(ADDR_PWM_CONFIG, 8'ha8);
		wr(ADDR_COMPARE_LOW_BASE + 8'h02, 8'h00);
		wr(ADDR_COMPARE_HIGH_BASE + 8'h02, 8'h00);
		wr(ADDR_PWM_CONFIG, 8'h28);
		rdc(ADDR_COMPARE_LOW_BASE + 8'h02, 8'hfe);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
		wr(ADDR_COUNTER_LOW, 8'hfe);
		wr(ADDR_COUNTER_HIGH, 8'hff);
		wr(ADDR_COUNTER_CONTROL, 8'h40);
		tick(2);
		chk({7'h00, module_pin_out[1]}, 8'h01);
		rdc(ADDR_COMPARE_LOW_BASE + 8'h02, 8'h00);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
		wr(ADDR_MODE_BASE + 8'h01, 8'h00);
	endtask : t_wide
	task automatic t_freq();
		wr(ADDR_COUNTER_LOW, 8'h00);
		wr(ADDR_COUNTER_HIGH, 8'h00);
		wr(ADDR_MODE_BASE + 8'h02, 8'h46);
		wr(ADDR_COMPARE_LOW_BASE + 8'h04, 8'h05);
		wr(ADDR_COMPARE_HIGH_BASE + 8'h04, 8'h03);
		wr(ADDR_COUNTER_CONTROL, 8'h40);
		tick(6);
		chk({7'h00, module_pin_out[2]}, 8'h01);
		rdc(ADDR_COMPARE_LOW_BASE + 8'h04, 8'h08);
		tick(3);
		chk({7'h00, module_pin_out[2]}, 8'h00);
		tick(3);
		chk({7'h00, module_pin_out[2]}, 8'h01);
		wr(ADDR_COMPARE_LOW_BASE + 8'h04, 8'h0e);
		tick(3);
		chk({7'h00, module_pin_out[2]}, 8'h01);
		wr(ADDR_MODE_BASE + 8'h02, 8'h4c);
		wr(ADDR_COUNTER_LOW, 8'h0e);
		wr(ADDR_COUNTER_HIGH, 8'h03);
		tick(1);
		chk({7'h00, module_pin_out[2]}, 8'h00);
		rdc(ADDR_COUNTER_CONTROL, 8'h44);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
	endtask : t_freq
	task automatic t_short();
		wr(ADDR_MODE_BASE, 8'h0a);
		wr(ADDR_PWM_CONFIG, 8'ha1);
		wr(ADDR_COMPARE_LOW_BASE, 8'hfe);
		wr(ADDR_COMPARE_HIGH_BASE, 8'h01);
		wr(ADDR_PWM_CONFIG, 8'h21);
		wr(ADDR_COMPARE_LOW_BASE, 8'hfe);
		wr(ADDR_COMPARE_HIGH_BASE, 8'h01);
		wr(ADDR_COUNTER_LOW, 8'hff);
		wr(ADDR_COUNTER_HIGH, 8'h00);
		wr(ADDR_COUNTER_CONTROL, 8'h40);
		tick(1);
		chk({7'h00, cycle_overflow_irq}, 8'h00);
		wr(ADDR_COUNTER_LOW, 8'hfe);
		wr(ADDR_COUNTER_HIGH, 8'h01);
		tick(1);
		chk({7'h00, module_pin_out[0]}, 8'h01);
		rdc(ADDR_COUNTER_CONTROL, 8'h41);
		tick(1);
		chk({7'h00, module_pin_out[0]}, 8'h00);
		chk({7'h00, cycle_overflow_irq}, 8'h01);
		wr(ADDR_COUNTER_CONTROL, 8'h00);
		wr(ADDR_MODE_BASE, 8'h00);
	endtask : t_short
	////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		{sfr_wr, sfr_rd, count_tick, watchdog_enable_bit} = 4'h0;
		{sfr_addr, sfr_wdata} = 16'h0000;
		ext_level = '0;
		fail_count = 0;
		checks = 0;
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		t_counter();
		t_capture();
		t_wide();
		t_freq();
		t_short();
		close_out();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule : counter_array_capture_compare_tb
`default_nettype wire
